// ==== logic/status_led_defs.svh ====
// Constants for the camera status indicator controller
`ifndef STATUS_LED_DEFS_SVH
`define STATUS_LED_DEFS_SVH
`define CLK_MHZ 125
`define ACQ_GAP_MS 100
`define ACQ_GAP_CYC (`ACQ_GAP_MS * 1000 * `CLK_MHZ)
`define SLOW_HALF_MS 500
`define SLOW_HALF_CYC (`SLOW_HALF_MS * 1000 * `CLK_MHZ)
`define FAST_HALF_MS 100
`define FAST_HALF_CYC (`FAST_HALF_MS * 1000 * `CLK_MHZ)
`define RED_HALF_MS 250
`define RED_HALF_CYC (`RED_HALF_MS * 1000 * `CLK_MHZ)
`define PWRUP_US 10
`define PWRUP_CYC (`PWRUP_US * `CLK_MHZ)
`define REG_CTRL 12'h000
`define REG_STAT 12'h004
`define CTRL_ENABLE_RST 1'h1
`endif

// ==== logic/status_led_pkg.sv ====
// Types for the camera status indicator controller
package status_led_pkg;
  typedef enum logic [8:0] {
    ST_PWRUP = 9'h001,
    ST_FATAL = 9'h002,
    ST_INIT = 9'h004,
    ST_NOLINK = 9'h008,
    ST_FILE = 9'h010,
    ST_ACQ = 9'h020,
    ST_APP = 9'h040,
    ST_IPOK = 9'h080,
    ST_WAIT = 9'h100
  } led_mode_t;
endpackage

// ==== logic/status_led_ctrl.sv ====
// Camera status indicator: priority resolve, flash patterns, APB regs
// Operation
// - Show only highest-priority active condition
// - Acquisition outranks address assigned
// - Steady red right after power-up
// - Steady red persists only on fatal uninitialised
// - Flash red during initialisation
// - Fatal error: steady red plus flashing blue
// - Camera restarts itself after fatal error (via presetn from the camera reset path, not by this module)
// - Link down: slow blue flash
// - File transfer: fast blue flash
// - Address assigned, no application: steady blue
// - Red then flashing blue awaiting address
// - No steady blue before address assigned
// - Green toggle per frame, 100ms apart
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "status_led_defs.svh"
module status_led_ctrl
  import status_led_pkg::*;
#(
  parameter int unsigned ACQ_GAP = `ACQ_GAP_CYC,
  parameter int unsigned SLOW_HALF = `SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = `FAST_HALF_CYC,
  parameter int unsigned RED_HALF = `RED_HALF_CYC,
  parameter int unsigned PWRUP = `PWRUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic init_busy,
  input wire logic init_done,
  input wire logic fatal_err,
  input wire logic link_up,
  input wire logic ip_assigned,
  input wire logic file_busy,
  input wire logic app_conn,
  input wire logic acq_active,
  input wire logic frame_done,
  output logic led_red,
  output logic led_green,
  output logic led_blue
);
  typedef struct packed {
    logic [31:0] div;
    logic [31:0] red_cnt;
    logic [31:0] acq_cnt;
    logic [31:0] pwr_cnt;
    logic [31:0] slow_cnt;
    logic slow;
    logic fast;
    logic redf;
    logic green_tgl;
    logic frame_pend;
    logic enable;
    led_mode_t mode;
    logic r;
    logic g;
    logic b;
    logic [31:0] rdata;
  } state_t;

  state_t q, d;

  function automatic logic wrap(input logic [31:0] c, input int unsigned n);
    return c >= 32'(n - 1);
  endfunction

  logic live;
  logic acc, wr_ok;

  // High once the power-up red interval is over
  assign live = q.pwr_cnt >= 32'(PWRUP);

  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = acc && paddr != `REG_CTRL && paddr != `REG_STAT;
  assign wr_ok = acc && pwrite && paddr == `REG_CTRL;
  assign prdata = q.rdata;
  assign led_red = q.r;
  assign led_green = q.g;
  assign led_blue = q.b;

  always_comb begin
    d = q;
    d.slow_cnt = q.slow_cnt + 32'h1;
    // Free-running dividers for the blue and red flashes
    d.div = q.div + 32'h1;
    if (wrap(q.div, FAST_HALF)) begin
      d.div = 32'h0;
      d.fast = !q.fast;
    end
    if (wrap(q.slow_cnt, SLOW_HALF)) begin
      d.slow_cnt = 32'h0;
      d.slow = !q.slow;
    end
    d.red_cnt = q.red_cnt + 32'h1;
    if (wrap(q.red_cnt, RED_HALF)) begin
      d.red_cnt = 32'h0;
      d.redf = !q.redf;
    end
    // Power-up steady red interval
    if (q.pwr_cnt < 32'(PWRUP)) begin
      d.pwr_cnt = q.pwr_cnt + 32'h1;
    end
    // Frame flashes rate limited
    if (q.acq_cnt != 32'h0) begin
      d.acq_cnt = q.acq_cnt - 32'h1;
    end
    if (frame_done && acq_active) begin
      d.frame_pend = 1'b1;
    end
    if (!acq_active) begin
      d.frame_pend = 1'b0;
      d.green_tgl = 1'b0;
    end else if ((q.frame_pend || frame_done) && q.acq_cnt == 32'h0) begin
      d.green_tgl = !q.green_tgl;
      d.frame_pend = 1'b0;
      d.acq_cnt = 32'(ACQ_GAP);
    end
    // Fixed priority resolve
    if (q.pwr_cnt < 32'(PWRUP)) begin
      d.mode = ST_PWRUP;
    end else if (fatal_err) begin
      d.mode = init_done ? ST_FATAL : ST_PWRUP;
    end else if (init_busy) begin
      d.mode = ST_INIT;
    end else if (!link_up) begin
      d.mode = ST_NOLINK;
    end else if (file_busy) begin
      d.mode = ST_FILE;
    end else if (acq_active) begin
      d.mode = ST_ACQ;
    end else if (app_conn) begin
      d.mode = ST_APP;
    end else if (ip_assigned) begin
      d.mode = ST_IPOK;
    end else begin
      d.mode = ST_WAIT;
    end
    d.r = 1'b0;
    d.g = 1'b0;
    d.b = 1'b0;
    if (q.enable) begin
      unique case (q.mode)
        ST_PWRUP: d.r = 1'b1;
        ST_FATAL: begin
          d.r = 1'b1;
          d.b = q.fast;
        end
        ST_INIT: d.r = q.redf;
        ST_NOLINK: d.b = q.slow;
        ST_FILE: d.b = q.fast;
        ST_ACQ: d.g = q.green_tgl;
        ST_APP: d.g = 1'b1;
        ST_IPOK: d.b = 1'b1;
        ST_WAIT: d.b = q.slow;
        default: d.r = 1'b1;
      endcase
    end
    if (wr_ok) begin
      d.enable = pwdata[0];
    end
    d.rdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      if (paddr == `REG_CTRL) begin
        d.rdata = {31'h0, q.enable};
      end else if (paddr == `REG_STAT) begin
        d.rdata = {20'h0, q.r, q.g, q.b, q.mode};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{
        div: 32'h0,
        red_cnt: 32'h0,
        acq_cnt: 32'h0,
        pwr_cnt: 32'h0,
        slow_cnt: 32'h0,
        slow: 1'b0,
        fast: 1'b0,
        redf: 1'b0,
        green_tgl: 1'b0,
        frame_pend: 1'b0,
        enable: `CTRL_ENABLE_RST,
        mode: ST_PWRUP,
        r: 1'b1,
        g: 1'b0,
        b: 1'b0,
        rdata: 32'h0
      };
    end else begin
      q <= d;
    end
  end

  // Restart after fatal error is done by the camera reset path

  pwrup_red_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_PWRUP && q.enable |=> led_red && !led_blue && !led_green)
    else $error("power-up mode not steady red");
  fatal_red_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_FATAL && q.enable |=> led_red && !led_green)
    else $error("fatal mode lost red");
  acq_over_ip_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.pwr_cnt >= 32'(PWRUP) && !fatal_err && !init_busy && link_up
    && !file_busy && acq_active && ip_assigned |=> q.mode == ST_ACQ)
    else $error("acquisition did not outrank address");
  no_blue_early_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_IPOK |-> $past(ip_assigned))
    else $error("steady blue before address");
  app_green_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_APP && q.enable |=> led_green && !led_blue && !led_red)
    else $error("application mode not green");
  gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(q.green_tgl) && acq_active |=> q.acq_cnt != 32'h0
    || ACQ_GAP <= 1)
    else $error("green toggles too close");
  init_red_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_INIT && q.enable |=> !led_blue && !led_green)
    else $error("init mode shows other colour");
  nolink_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_NOLINK && q.enable |=> led_blue == $past(q.slow))
    else $error("link-down not slow blue");
  file_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_FILE && q.enable |=> led_blue == $past(q.fast))
    else $error("file transfer not fast blue");
  ip_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_IPOK && q.enable |=> led_blue && !led_red)
    else $error("address mode not steady blue");

  // Priority resolve, one check per level except acquisition (see acq_over_ip_a)
  prio_fatal_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && fatal_err && init_done |=> q.mode == ST_FATAL)
    else $error("fatal error not top priority");
  fatal_uninit_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && fatal_err && !init_done |=> q.mode == ST_PWRUP)
    else $error("uninitialised fatal not steady red");
  pwrup_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !live |=> q.mode == ST_PWRUP)
    else $error("left power-up red too early");
  init_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && !fatal_err && init_busy |=> q.mode == ST_INIT)
    else $error("initialisation mode not chosen");
  nolink_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && !fatal_err && !init_busy && !link_up |=> q.mode == ST_NOLINK)
    else $error("link-down mode not chosen");
  file_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && !fatal_err && !init_busy && link_up && file_busy
    |=> q.mode == ST_FILE)
    else $error("file transfer mode not chosen");
  app_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && !fatal_err && !init_busy && link_up && !file_busy
    && !acq_active && app_conn |=> q.mode == ST_APP)
    else $error("application mode not chosen");
  ip_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && !fatal_err && !init_busy && link_up && !file_busy
    && !acq_active && !app_conn && ip_assigned |=> q.mode == ST_IPOK)
    else $error("address mode not chosen");
  wait_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    live && !fatal_err && !init_busy && link_up && !file_busy
    && !acq_active && !app_conn && !ip_assigned |=> q.mode == ST_WAIT)
    else $error("waiting mode not chosen");

  // Pattern per mode
  init_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_INIT && q.enable |=> led_red == $past(q.redf))
    else $error("init red not flashing");
  fatal_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_FATAL && q.enable |=> led_blue == $past(q.fast))
    else $error("fatal blue not flashing");
  wait_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_WAIT && q.enable
    |=> led_blue == $past(q.slow) && !led_red && !led_green)
    else $error("waiting not slow blue");
  acq_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    q.mode == ST_ACQ && q.enable
    |=> led_green == $past(q.green_tgl) && !led_red && !led_blue)
    else $error("acquisition not green toggle");
  dark_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !q.enable |=> !led_red && !led_green && !led_blue)
    else $error("indicator lit while disabled");

  // Divider flashes toggle only at wrap
  fast_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(q.fast) |-> q.div == 32'h0)
    else $error("fast flash off its divider");
  slow_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(q.slow) |-> q.slow_cnt == 32'h0)
    else $error("slow flash off its divider");

  acq_c: cover property (@(posedge pclk) q.mode == ST_ACQ && led_green);
  fatal_c: cover property (@(posedge pclk) q.mode == ST_FATAL && led_blue);
  wait_c: cover property (@(posedge pclk) q.mode == ST_WAIT ##1 q.mode == ST_IPOK);
  init_c: cover property (@(posedge pclk) q.mode == ST_INIT && led_red);
  app_c: cover property (@(posedge pclk) q.mode == ST_APP && led_green);
endmodule
`default_nettype wire

// ==== verif/led_view.sv ====
// Operator's view of the indicator: counts colour changes
`timescale 1ns/10ps
`default_nettype none
module led_view (
  input wire logic pclk,
  input wire logic led_red,
  input wire logic led_green,
  input wire logic led_blue,
  output logic [7:0] n_red,
  output logic [7:0] n_green,
  output logic [7:0] n_blue
);
  logic [2:0] last_q = 3'h4;
  initial n_red = 8'h00;
  initial n_green = 8'h00;
  initial n_blue = 8'h00;
  always @(posedge pclk) begin
    if (led_red !== last_q[2]) n_red <= n_red + 8'h01;
    if (led_green !== last_q[1]) n_green <= n_green + 8'h01;
    if (led_blue !== last_q[0]) n_blue <= n_blue + 8'h01;
    last_q <= {led_red, led_green, led_blue};
  end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Bench for the status indicator controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import status_led_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, red, green, blue, frame = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, leds;
  logic [7:0] cond = 8'h00, n_r, n_g, n_b, d_r, d_g, d_b;
  int errors = 0, tests_run = 0;
  assign leds = {29'h0, red, green, blue};
  always #4 pclk = ~pclk;
  status_led_ctrl #(.ACQ_GAP(20), .SLOW_HALF(8), .FAST_HALF(4),
    .RED_HALF(6), .PWRUP(5)) i_status_led_ctrl (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .init_busy(cond[7]), .init_done(cond[6]),
    .fatal_err(cond[5]), .link_up(cond[4]), .ip_assigned(cond[3]),
    .file_busy(cond[2]), .app_conn(cond[1]), .acq_active(cond[0]),
    .frame_done(frame), .led_red(red), .led_green(green), .led_blue(blue));
  led_view i_led_view (.pclk(pclk), .led_red(red), .led_green(green),
    .led_blue(blue), .n_red(n_r), .n_green(n_g), .n_blue(n_b));
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task rng(input string s, input logic [31:0] lo, input logic [31:0] hi,
    input logic [31:0] g);
    tests_run++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("Error %s expected %0d to %0d seen %0d", s, lo, hi, g);
    end
  endtask
  task test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task watch(input int n);
    logic [7:0] r0, g0, b0;
    r0 = n_r;
    g0 = n_g;
    b0 = n_b;
    repeat (n) @(posedge pclk);
    d_r = n_r - r0;
    d_g = n_g - g0;
    d_b = n_b - b0;
  endtask
  task mode(input logic [7:0] c, input led_mode_t m);
    logic [31:0] r;
    logic e;
    cond <= c;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk("mode", 32'(m), {23'h0, r[8:0]});
  endtask
  task t_reset;
    repeat (4) @(posedge pclk);
    chk("rst_led", 32'h4, leds);
    presetn <= 1'b1;
    watch(4);
    chk("pwrup_led", 32'h4, leds);
    chk("pwrup_tog", 32'h0, {24'h0, d_r});
  endtask
  task t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk("ctrl_rst", 32'h1, r);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b1, 12'h000, 32'h0, r, e);
    watch(3);
    chk("led_off", 32'h0, leds);
    apb(1'b1, 12'h000, 32'h1, r, e);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk("bad_err", 32'h1, {31'h0, e});
    chk("bad_data", 32'h0, r);
  endtask
  task t_fatal;
    mode(8'h20, ST_PWRUP);
    watch(24);
    chk("fatal_led", 32'h4, leds);
    rng("fatal_tog", 0, 0, d_r + d_b);
    mode(8'h60, ST_FATAL);
    watch(24);
    chk("fatal_red", 32'h1, {31'h0, red});
    rng("fatal_blue", 5, 7, d_b);
  endtask
  task t_init;
    mode(8'h80, ST_INIT);
    watch(24);
    rng("init_red", 3, 5, d_r);
  endtask
  task t_blue;
    mode(8'h40, ST_NOLINK);
    watch(32);
    rng("slow_blue", 3, 5, d_b);
    mode(8'h5F, ST_FILE);
    watch(32);
    rng("fast_blue", 7, 9, d_b);
  endtask
  task t_prio;
    mode(8'hFF, ST_FATAL);
    mode(8'h5A, ST_APP);
    watch(16);
    chk("app_led", 32'h2, leds);
    mode(8'h58, ST_IPOK);
    watch(16);
    chk("ip_led", 32'h1, leds);
    rng("ip_tog", 0, 0, d_b);
    mode(8'h50, ST_WAIT);
    watch(32);
    rng("wait_blue", 3, 5, d_b);
  endtask
  task t_acq;
    int gap, gmin, tg;
    logic g0;
    mode(8'h5B, ST_ACQ);
    gap = 0;
    gmin = 255;
    tg = 0;
    g0 = green;
    repeat (120) begin
      frame <= ~frame;
      @(posedge pclk);
      gap++;
      if (green !== g0) begin
        if (tg > 1 && gap < gmin) gmin = gap;
        tg++;
        gap = 0;
        g0 = green;
      end
    end
    frame <= 1'b0;
    rng("acq_tog", 3, 7, tg);
    rng("acq_gap", 20, 255, gmin);
  endtask
  task t_reboot;
    mode(8'h60, ST_FATAL);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("boot_led", 32'h4, leds);
    cond <= 8'h5A;
    presetn <= 1'b1;
    watch(3);
    chk("boot_red", 32'h4, leds);
    mode(8'h5A, ST_APP);
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    errors++;
    test_done;
  end
  initial begin
    t_reset;
    t_regs;
    t_fatal;
    t_init;
    t_blue;
    t_prio;
    t_acq;
    t_reboot;
    test_done;
  end
endmodule
`default_nettype wire
